// File: design/mpp_pkg.sv
// Purpose: Shared constants and types of the motion profile parameter set.
// Assumes: Parameter numbers are the documented word numbers.
// Notes:   Two-word parameters are reached at their first number only.
package mpp_pkg;

  // ************************************************************
  // Parameter table
  // ************************************************************
  localparam int          MPP_NUM_PRM   = 20;
  localparam int          MPP_ADDR_W    = 12;
  localparam int          MPP_DATA_W    = 32;
  localparam logic [4:0]  MPP_IDX_NONE  = 5'h1F;
  localparam logic [11:0] MPP_ADDR [MPP_NUM_PRM] = '{
    12'h080A, 12'h080B, 12'h080C, 12'h080D, 12'h080E, 12'h080F,
    12'h0810, 12'h0811, 12'h0812, 12'h0814, 12'h0817, 12'h0818,
    12'h0819, 12'h0820, 12'h0822, 12'h0827, 12'h0833, 12'h0834,
    12'h0842, 12'h0844};
  localparam logic [31:0] MPP_RESET [MPP_NUM_PRM] = '{
    32'h0000_0064, 32'h0000_0064, 32'h0000_0000, 32'h0000_0064,
    32'h0000_0064, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0064, 32'h0000_0032, 32'h0000_0005,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0064,
    32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_0000};
  localparam logic signed [32:0] MPP_MIN [MPP_NUM_PRM] = '{
    33'sh0_0000_0001, 33'sh0_0000_0001, 33'sh0_0000_0000,
    33'sh0_0000_0001, 33'sh0_0000_0001, 33'sh0_0000_0000,
    33'sh0_0000_0000, 33'sh0_0000_0000, 33'sh0_0000_0000,
    33'sh1_C000_0001, 33'sh0_0000_0000, 33'sh0_0000_0000,
    33'sh1_C000_0001, 33'sh1_8000_0000, 33'sh1_8000_0000,
    33'sh0_0000_0001, 33'sh0_0000_0000, 33'sh0_0000_0001,
    33'sh0_0000_0000, 33'sh0_0000_0000};
  localparam logic signed [32:0] MPP_MAX [MPP_NUM_PRM] = '{
    33'sh0_0000_FFFF, 33'sh0_0000_FFFF, 33'sh0_0000_FFFF,
    33'sh0_0000_FFFF, 33'sh0_0000_FFFF, 33'sh0_0000_FFFF,
    33'sh0_0000_FFFF, 33'sh0_0000_13EC, 33'sh0_0000_13EC,
    33'sh0_3FFF_FFFF, 33'sh0_0000_FFFF, 33'sh0_0000_FFFF,
    33'sh0_3FFF_FFFF, 33'sh0_7FFF_FFFF, 33'sh0_7FFF_FFFF,
    33'sh0_0000_FFFF, 33'sh0_0000_0001, 33'sh0_0140_0000,
    33'sh0_0140_0000, 33'sh0_0140_0000};
  // Set where the parameter is a signed quantity.
  localparam logic [MPP_NUM_PRM-1:0] MPP_SIGNED = 20'h0_7200;

  // Table indices used by the logic.
  localparam int MPP_I_ACC1_S1  = 0;
  localparam int MPP_I_ACC2_S1  = 1;
  localparam int MPP_I_ACC_SW   = 2;
  localparam int MPP_I_DEC1_S1  = 3;
  localparam int MPP_I_DEC2_S1  = 4;
  localparam int MPP_I_DEC_SW   = 5;
  localparam int MPP_I_BIAS     = 6;
  localparam int MPP_I_TCONST   = 7;
  localparam int MPP_I_MAVG     = 8;
  localparam int MPP_I_LATCH_D  = 9;
  localparam int MPP_I_CREEP1   = 10;
  localparam int MPP_I_CREEP2   = 11;
  localparam int MPP_I_HOME_D   = 12;
  localparam int MPP_I_WIN_FWD  = 13;
  localparam int MPP_I_WIN_REV  = 14;
  localparam int MPP_I_STOP_DEC = 15;
  localparam int MPP_I_RSEL     = 16;
  localparam int MPP_I_ACC1_S2  = 17;
  localparam int MPP_I_CREEP1X  = 18;
  localparam int MPP_I_CREEP2X  = 19;
  localparam int MPP_RSEL_W     = 4;
  localparam int MPP_SYNC_N     = 2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic positioning_cmd;
    logic external_positioning_cmd;
    logic feed_cmd;
    logic homing_cmd;
    logic hold_cmd;
    logic servo_off_cmd;
  } mpp_cmd_t;

  typedef struct packed {
    logic [15:0] expo_bias;
    logic [15:0] expo_time_const;
    logic [15:0] moving_avg_time;
  } mpp_filter_t;

  typedef enum logic [2:0] {
    MPP_IDLE     = 3'b000,
    MPP_MOVE     = 3'b001,
    MPP_LATCH_MV = 3'b010,
    MPP_HOME_APP = 3'b011,
    MPP_HOME_C1  = 3'b100,
    MPP_HOME_C2  = 3'b101,
    MPP_STOP     = 3'b110
  } mpp_state_t;

endpackage

// File: design/mpp_rate_pick.sv
// Purpose: Picks the first or second rate against a switch speed.
// Assumes: Speed and switch speed share the same unit.
// Notes:   Output is registered so a speed change lands a cycle later.
`timescale 1ns/100ps
`default_nettype none
module mpp_rate_pick #(
  parameter int RATE_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [31:0]       i_speed,
  input  wire logic [15:0]       i_switch_speed,
  input  wire logic [RATE_W-1:0] i_rate_first,
  input  wire logic [RATE_W-1:0] i_rate_second,
  input  wire logic [RATE_W-1:0] i_rate_reset,
  output logic [RATE_W-1:0]      o_rate
);
  logic use_second;

  // A zero switch speed keeps the first rate for the whole move.
  assign use_second = (i_switch_speed != '0)
                      && (i_speed >= {16'h0000, i_switch_speed});

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rate <= i_rate_reset;
    end else begin
      o_rate <= use_second ? i_rate_second : i_rate_first;
    end
  end
endmodule
`default_nettype wire

// File: design/mpp_sync.sv
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: The pin is asynchronous to I_CLK.
// Notes:   Only the second stage may be read by logic.
`timescale 1ns/100ps
`default_nettype none
module mpp_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level
);
  logic meta_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q  <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_q  <= i_pin;
      o_level <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: design/mpp_top.sv
// Purpose: Motion profile and homing parameter set of a servo amplifier.
// Assumes: Parameter port driven by the fieldbus command decoder on I_CLK.
// Notes:   Pins for latch and decel switch are synchronised here.
`timescale 1ns/100ps
`default_nettype none
module mpp_top (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_RESTART,
  input  wire logic                  I_PRM_WR,
  input  wire logic                  I_PRM_RD,
  input  wire logic [11:0]           I_PRM_NUM,
  input  wire logic [31:0]           I_PRM_WDATA,
  output logic [31:0]                O_PRM_RDATA,
  output logic                       O_PRM_ACK,
  output logic                       O_PRM_ERR,
  input  wire mpp_pkg::mpp_cmd_t     I_CMD,
  input  wire logic [31:0]           I_CMD_SPEED,
  input  wire logic signed [31:0]    I_POSITION,
  input  wire logic                  I_LATCH_PIN,
  input  wire logic                  I_HOME_DECEL_SWITCH,
  output logic [31:0]                O_ACCEL_RATE,
  output logic [15:0]                O_DECEL_RATE,
  output logic                       O_RATE_SET_2,
  output mpp_pkg::mpp_filter_t       O_FILTER,
  output logic [31:0]                O_CREEP_SPEED,
  output logic signed [31:0]         O_TRAVEL_DIST,
  output logic                       O_TRAVEL_VALID,
  output logic                       O_LATCH_TAKEN,
  output logic                       O_HOME_DONE,
  output mpp_pkg::mpp_state_t        O_STATE
);

  // ************************************************************
  // Parameter store
  // ************************************************************
  logic [31:0]                  prm_q [mpp_pkg::MPP_NUM_PRM];
  logic [4:0]                   hit_idx;
  logic                         in_range;
  logic signed [32:0]           wdata_ext;
  logic [mpp_pkg::MPP_RSEL_W-1:0] rsel_active_q;

  // Maps a parameter number onto its table entry.
  function automatic logic [4:0] prm_index(input logic [11:0] num);
    logic [4:0] idx;
    idx = mpp_pkg::MPP_IDX_NONE;
    for (int k = 0; k < mpp_pkg::MPP_NUM_PRM; k++) begin
      if (num == mpp_pkg::MPP_ADDR[k]) begin
        idx = 5'(k);
      end
    end
    return idx;
  endfunction

  assign hit_idx = prm_index(I_PRM_NUM);

  always_comb begin
    wdata_ext = 33'(signed'(I_PRM_WDATA));
    in_range  = 1'b0;
    if (hit_idx != mpp_pkg::MPP_IDX_NONE) begin
      if (!mpp_pkg::MPP_SIGNED[hit_idx]) begin
        wdata_ext = {1'b0, I_PRM_WDATA};
      end
      // Out-of-range writes are refused so the profile never sees a
      // rate of zero or a distance outside the coordinate span.
      in_range = (wdata_ext >= mpp_pkg::MPP_MIN[hit_idx])
                 && (wdata_ext <= mpp_pkg::MPP_MAX[hit_idx]);
    end
  end

  generate
    for (genvar g = 0; g < mpp_pkg::MPP_NUM_PRM; g++) begin : g_prm
      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          prm_q[g] <= mpp_pkg::MPP_RESET[g];
        end else if (I_PRM_WR && in_range && hit_idx == 5'(g)) begin
          prm_q[g] <= I_PRM_WDATA;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Parameter port answer
  // ************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PRM_RDATA <= '0;
      O_PRM_ACK   <= 1'b0;
      O_PRM_ERR   <= 1'b0;
    end else begin
      O_PRM_ACK <= I_PRM_WR || I_PRM_RD;
      O_PRM_ERR <= (I_PRM_WR && !in_range)
                   || (I_PRM_RD && hit_idx == mpp_pkg::MPP_IDX_NONE);
      if (I_PRM_RD && hit_idx != mpp_pkg::MPP_IDX_NONE) begin
        O_PRM_RDATA <= prm_q[hit_idx];
      end else begin
        O_PRM_RDATA <= '0;
      end
    end
  end

  // ************************************************************
  // Restart-required selector
  // ************************************************************
  // The stored selector reads back at once, but the profile keeps the
  // set that was active at the last restart.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rsel_active_q <= '0;
    end else if (I_RESTART) begin
      rsel_active_q <= prm_q[mpp_pkg::MPP_I_RSEL][3:0];
    end
  end

  assign O_RATE_SET_2 = (rsel_active_q != '0);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic latch_lvl;
  logic decel_lvl;
  logic latch_prev_q;
  logic decel_prev_q;
  logic latch_rise;
  logic decel_rise;

  mpp_sync u_sync_latch (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_pin   (I_LATCH_PIN),
    .o_level (latch_lvl)
  );

  mpp_sync u_sync_decel (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_pin   (I_HOME_DECEL_SWITCH),
    .o_level (decel_lvl)
  );

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      latch_prev_q <= 1'b0;
      decel_prev_q <= 1'b0;
    end else begin
      latch_prev_q <= latch_lvl;
      decel_prev_q <= decel_lvl;
    end
  end

  assign decel_rise = decel_lvl && !decel_prev_q;

  // ************************************************************
  // Latch ready area
  // ************************************************************
  logic signed [31:0] win_fwd;
  logic signed [31:0] win_rev;
  logic               in_window;

  assign win_fwd = signed'(prm_q[mpp_pkg::MPP_I_WIN_FWD]);
  assign win_rev = signed'(prm_q[mpp_pkg::MPP_I_WIN_REV]);
  // An empty area (forward not above reverse) leaves latching open.
  assign in_window = (win_fwd <= win_rev)
                     || (I_POSITION >= win_rev && I_POSITION <= win_fwd);
  assign latch_rise = latch_lvl && !latch_prev_q && in_window;

  // ************************************************************
  // Rate selection against speed
  // ************************************************************
  logic [31:0] accel_s1;
  logic [15:0] decel_s1;

  mpp_rate_pick #(
    .RATE_W (32)
  ) u_pick_accel (
    .i_clk          (I_CLK),
    .i_rst          (I_RST),
    .i_speed        (I_CMD_SPEED),
    .i_switch_speed (prm_q[mpp_pkg::MPP_I_ACC_SW][15:0]),
    .i_rate_first   ({16'h0000, prm_q[mpp_pkg::MPP_I_ACC1_S1][15:0]}),
    .i_rate_second  ({16'h0000, prm_q[mpp_pkg::MPP_I_ACC2_S1][15:0]}),
    .i_rate_reset   (mpp_pkg::MPP_RESET[mpp_pkg::MPP_I_ACC1_S1]),
    .o_rate         (accel_s1)
  );

  mpp_rate_pick #(
    .RATE_W (16)
  ) u_pick_decel (
    .i_clk          (I_CLK),
    .i_rst          (I_RST),
    .i_speed        (I_CMD_SPEED),
    .i_switch_speed (prm_q[mpp_pkg::MPP_I_DEC_SW][15:0]),
    .i_rate_first   (prm_q[mpp_pkg::MPP_I_DEC1_S1][15:0]),
    .i_rate_second  (prm_q[mpp_pkg::MPP_I_DEC2_S1][15:0]),
    .i_rate_reset   (mpp_pkg::MPP_RESET[mpp_pkg::MPP_I_DEC1_S1][15:0]),
    .o_rate         (decel_s1)
  );

  // ************************************************************
  // Command sequencer
  // ************************************************************
  mpp_pkg::mpp_state_t state_q;
  mpp_pkg::mpp_state_t state_d;
  logic                any_move;
  logic                any_stop;

  assign any_move = I_CMD.positioning_cmd || I_CMD.feed_cmd;
  assign any_stop = I_CMD.hold_cmd || I_CMD.servo_off_cmd;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mpp_pkg::MPP_IDLE,
      mpp_pkg::MPP_MOVE,
      mpp_pkg::MPP_STOP: begin
        if (any_stop) begin
          state_d = mpp_pkg::MPP_STOP;
        end else if (I_CMD.homing_cmd) begin
          state_d = mpp_pkg::MPP_HOME_APP;
        end else if (I_CMD.external_positioning_cmd) begin
          state_d = mpp_pkg::MPP_LATCH_MV;
        end else if (any_move) begin
          state_d = mpp_pkg::MPP_MOVE;
        end else begin
          state_d = mpp_pkg::MPP_IDLE;
        end
      end
      mpp_pkg::MPP_LATCH_MV: begin
        if (any_stop) begin
          state_d = mpp_pkg::MPP_STOP;
        end else if (latch_rise) begin
          state_d = mpp_pkg::MPP_MOVE;
        end
      end
      mpp_pkg::MPP_HOME_APP: begin
        if (any_stop) begin
          state_d = mpp_pkg::MPP_STOP;
        end else if (decel_rise) begin
          state_d = mpp_pkg::MPP_HOME_C1;
        end
      end
      mpp_pkg::MPP_HOME_C1: begin
        if (any_stop) begin
          state_d = mpp_pkg::MPP_STOP;
        end else if (latch_rise) begin
          state_d = mpp_pkg::MPP_HOME_C2;
        end
      end
      mpp_pkg::MPP_HOME_C2: begin
        if (any_stop) begin
          state_d = mpp_pkg::MPP_STOP;
        end else begin
          state_d = mpp_pkg::MPP_IDLE;
        end
      end
      default: begin
        state_d = mpp_pkg::MPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q <= mpp_pkg::MPP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign O_STATE = state_q;

  // ************************************************************
  // Travel after latch and homing completion
  // ************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_TRAVEL_DIST  <= '0;
      O_TRAVEL_VALID <= 1'b0;
      O_LATCH_TAKEN  <= 1'b0;
      O_HOME_DONE    <= 1'b0;
    end else begin
      O_TRAVEL_VALID <= 1'b0;
      O_LATCH_TAKEN  <= 1'b0;
      O_HOME_DONE    <= 1'b0;
      if (state_q == mpp_pkg::MPP_LATCH_MV && state_d
          == mpp_pkg::MPP_MOVE) begin
        O_TRAVEL_DIST  <= signed'(prm_q[mpp_pkg::MPP_I_LATCH_D]);
        O_TRAVEL_VALID <= 1'b1;
        O_LATCH_TAKEN  <= 1'b1;
      end else if (state_q == mpp_pkg::MPP_HOME_C1 && state_d
                   == mpp_pkg::MPP_HOME_C2) begin
        O_TRAVEL_DIST  <= signed'(prm_q[mpp_pkg::MPP_I_HOME_D]);
        O_TRAVEL_VALID <= 1'b1;
        O_LATCH_TAKEN  <= 1'b1;
      end else if (state_q == mpp_pkg::MPP_HOME_C2 && state_d
                   == mpp_pkg::MPP_IDLE) begin
        O_HOME_DONE <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Profile outputs
  // ************************************************************
  logic [31:0] creep1;
  logic [31:0] creep2;

  // A zero in the short field hands over to the wide field.
  assign creep1 = (prm_q[mpp_pkg::MPP_I_CREEP1][15:0] == '0)
                  ? prm_q[mpp_pkg::MPP_I_CREEP1X]
                  : prm_q[mpp_pkg::MPP_I_CREEP1];
  assign creep2 = (prm_q[mpp_pkg::MPP_I_CREEP2][15:0] == '0)
                  ? prm_q[mpp_pkg::MPP_I_CREEP2X]
                  : prm_q[mpp_pkg::MPP_I_CREEP2];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CREEP_SPEED <= '0;
    end else if (state_q == mpp_pkg::MPP_HOME_C1) begin
      O_CREEP_SPEED <= creep1;
    end else if (state_q == mpp_pkg::MPP_HOME_C2) begin
      O_CREEP_SPEED <= creep2;
    end else begin
      O_CREEP_SPEED <= '0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_ACCEL_RATE <= mpp_pkg::MPP_RESET[mpp_pkg::MPP_I_ACC1_S1];
      O_DECEL_RATE <= mpp_pkg::MPP_RESET[mpp_pkg::MPP_I_DEC1_S1][15:0];
    end else begin
      // Set-2 decel rates live outside this block; here only its
      // first acceleration is supplied.
      O_ACCEL_RATE <= O_RATE_SET_2 ? prm_q[mpp_pkg::MPP_I_ACC1_S2]
                                   : accel_s1;
      if (state_q == mpp_pkg::MPP_STOP) begin
        O_DECEL_RATE <= prm_q[mpp_pkg::MPP_I_STOP_DEC][15:0];
      end else begin
        O_DECEL_RATE <= decel_s1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_FILTER <= '0;
    end else begin
      O_FILTER.expo_bias       <= prm_q[mpp_pkg::MPP_I_BIAS][15:0];
      O_FILTER.expo_time_const <= prm_q[mpp_pkg::MPP_I_TCONST][15:0];
      O_FILTER.moving_avg_time <= prm_q[mpp_pkg::MPP_I_MAVG][15:0];
    end
  end

endmodule
`default_nettype wire

// File: tb/mpp_ctrl_model.sv
// Purpose: Fieldbus controller stand-in that issues motion commands.
// Assumes: One command code at a time from the bench.
// Notes:   Code 0 is none; 1 to 6 follow the command struct order.
`timescale 1ns/100ps
`default_nettype none
module mpp_ctrl_model (
  input  wire logic             i_clk,
  input  wire logic [2:0]       i_code,
  output var mpp_pkg::mpp_cmd_t o_cmd
);
  // ************************************************************
  // Command issue
  // ************************************************************
  // Commands stand as levels so the sequencer sees them every cycle.
  always @(posedge i_clk) begin
    o_cmd <= (i_code == 3'h0) ? '0 :
             mpp_pkg::mpp_cmd_t'(6'h20 >> (i_code - 3'h1));
  end
endmodule
`default_nettype wire

// File: tb/mpp_properties.sv
// Purpose: Port checks for the motion profile parameter set.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Watches design inputs and outputs, through the bind below.
`timescale 1ns/100ps
`default_nettype none
module mpp_properties (
  input wire logic                I_CLK,
  input wire logic                I_RST,
  input wire logic                I_RESTART,
  input wire logic                I_PRM_WR,
  input wire logic                I_PRM_RD,
  input wire mpp_pkg::mpp_cmd_t   I_CMD,
  input wire logic [31:0]         O_PRM_RDATA,
  input wire logic                O_PRM_ACK,
  input wire logic                O_PRM_ERR,
  input wire logic                O_RATE_SET_2,
  input wire logic [31:0]         O_CREEP_SPEED,
  input wire logic                O_TRAVEL_VALID,
  input wire logic                O_LATCH_TAKEN,
  input wire logic                O_HOME_DONE,
  input wire mpp_pkg::mpp_state_t O_STATE
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  ack_follows_a: assert property (I_PRM_WR || I_PRM_RD |=> O_PRM_ACK)
    else $error("no ack after request");
  ack_cause_a: assert property (
    O_PRM_ACK || O_PRM_ERR |-> $past(I_PRM_WR) || $past(I_PRM_RD))
    else $error("ack without request");
  rdata_idle_a: assert property (!I_PRM_RD |=> O_PRM_RDATA == '0)
    else $error("read data not cleared");
  sel_waits_a: assert property (!I_RESTART |=> $stable(O_RATE_SET_2))
    else $error("rate set moved without restart");
  hold_stops_a: assert property (
    I_CMD.hold_cmd || I_CMD.servo_off_cmd |=> O_STATE == mpp_pkg::MPP_STOP)
    else $error("hold did not stop");
  creep_idle_a: assert property (
    O_STATE == mpp_pkg::MPP_IDLE && $past(O_STATE) == mpp_pkg::MPP_IDLE
    |-> O_CREEP_SPEED == '0)
    else $error("creep speed outside homing");
  home_end_a: assert property (O_STATE == mpp_pkg::MPP_HOME_C2
    && !(I_CMD.hold_cmd || I_CMD.servo_off_cmd)
    |=> O_STATE == mpp_pkg::MPP_IDLE && O_HOME_DONE)
    else $error("homing did not complete");
  done_cause_a: assert property (
    O_HOME_DONE |-> $past(O_STATE) == mpp_pkg::MPP_HOME_C2)
    else $error("done without final creep");
  latch_pair_a: assert property (O_LATCH_TAKEN |-> O_TRAVEL_VALID)
    else $error("latch taken without travel");
endmodule

bind mpp_top mpp_properties u_mpp_properties (.I_CLK, .I_RST, .I_RESTART,
  .I_PRM_WR, .I_PRM_RD, .I_CMD, .O_PRM_RDATA, .O_PRM_ACK, .O_PRM_ERR,
  .O_RATE_SET_2, .O_CREEP_SPEED, .O_TRAVEL_VALID, .O_LATCH_TAKEN,
  .O_HOME_DONE, .O_STATE);
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the motion profile parameter set.
// Assumes: One-cycle ack on the parameter port.
// Notes:   Commands come from the controller stand-in model.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic I_CLK, I_RST, I_RESTART, I_PRM_WR, I_PRM_RD;
  logic I_LATCH_PIN, I_HOME_DECEL_SWITCH, O_PRM_ACK, O_PRM_ERR;
  logic O_RATE_SET_2, O_TRAVEL_VALID, O_LATCH_TAKEN, O_HOME_DONE;
  logic [11:0] I_PRM_NUM;
  logic [31:0] I_PRM_WDATA, I_CMD_SPEED, O_PRM_RDATA, O_ACCEL_RATE;
  logic [31:0] O_CREEP_SPEED;
  logic [15:0] O_DECEL_RATE;
  logic signed [31:0] I_POSITION, O_TRAVEL_DIST;
  logic [2:0] code;
  mpp_pkg::mpp_cmd_t I_CMD;
  mpp_pkg::mpp_filter_t O_FILTER;
  mpp_pkg::mpp_state_t O_STATE;
  int fail_count = 0;
  int num_checks = 0;
  logic [11:0] bad_num [6] = '{12'h080D, 12'h0811, 12'h0833, 12'h0834,
    12'h0814, 12'h0815};
  logic [31:0] bad_dat [6] = '{32'h0000_0000, 32'h0000_13ED, 32'h0000_0002,
    32'h0140_0001, 32'h4000_0000, 32'h0000_0001};
  logic [31:0] bad_def [6] = '{32'h0000_0064, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0064, 32'h0000_0064, 32'h0000_0000};
  mpp_pkg::mpp_state_t want [6] = '{mpp_pkg::MPP_MOVE, mpp_pkg::MPP_LATCH_MV,
    mpp_pkg::MPP_MOVE, mpp_pkg::MPP_HOME_APP, mpp_pkg::MPP_STOP,
    mpp_pkg::MPP_STOP};

  mpp_ctrl_model u_mpp_ctrl_model (.i_clk(I_CLK), .i_code(code),
    .o_cmd(I_CMD));
  mpp_top u_mpp_top (.I_CLK, .I_RST, .I_RESTART, .I_PRM_WR, .I_PRM_RD,
    .I_PRM_NUM, .I_PRM_WDATA, .O_PRM_RDATA, .O_PRM_ACK, .O_PRM_ERR, .I_CMD,
    .I_CMD_SPEED, .I_POSITION, .I_LATCH_PIN, .I_HOME_DECEL_SWITCH,
    .O_ACCEL_RATE, .O_DECEL_RATE, .O_RATE_SET_2, .O_FILTER, .O_CREEP_SPEED,
    .O_TRAVEL_DIST, .O_TRAVEL_VALID, .O_LATCH_TAKEN, .O_HOME_DONE, .O_STATE);

  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end

  // ************************************************************
  // Access and check tasks
  // ************************************************************
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Sampling 1 ns after the edge lets that edge's register updates land.
  task automatic step(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask

  task automatic wr(input logic [11:0] n, input logic [31:0] d,
                    input logic e);
    @(posedge I_CLK);
    I_PRM_WR <= 1'b1;
    I_PRM_NUM <= n;
    I_PRM_WDATA <= d;
    @(posedge I_CLK);
    I_PRM_WR <= 1'b0;
    #1;
    chk("write ack", 32'h0000_0001, 32'(O_PRM_ACK));
    chk("write err", 32'(e), 32'(O_PRM_ERR));
  endtask

  task automatic rd(input logic [11:0] n, input logic [31:0] d,
                    input logic e);
    @(posedge I_CLK);
    I_PRM_RD <= 1'b1;
    I_PRM_NUM <= n;
    @(posedge I_CLK);
    I_PRM_RD <= 1'b0;
    #1;
    chk("read data", d, O_PRM_RDATA);
    chk("read err", 32'(e), 32'(O_PRM_ERR));
  endtask

  // A wait that runs out ends the run as a mismatch.
  task automatic wait_for(input mpp_pkg::mpp_state_t s, input logic v);
    for (int i = 0; i < 50; i++) begin
      step(1);
      if (v ? O_TRAVEL_VALID === 1'b1 : O_STATE === s) return;
    end
    fail_count++;
    $display("Error wait expected %h seen %h", s, O_STATE);
    print_verdict();
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    I_RST = 1'b1;
    {I_RESTART, I_PRM_WR, I_PRM_RD, I_LATCH_PIN, I_HOME_DECEL_SWITCH} = '0;
    {I_PRM_NUM, I_PRM_WDATA, I_CMD_SPEED, code} = '0;
    I_POSITION = 32'sh0000_0032;
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    for (int k = 0; k < mpp_pkg::MPP_NUM_PRM; k++)
      rd(mpp_pkg::MPP_ADDR[k], mpp_pkg::MPP_RESET[k], 1'b0);
    chk("accel", 32'h0000_0064, O_ACCEL_RATE);
    chk("decel", 32'h0000_0064, 32'(O_DECEL_RATE));
    $display("Test defaults done");
    for (int k = 0; k < 6; k++) begin
      wr(bad_num[k], bad_dat[k], 1'b1);
      rd(bad_num[k], bad_def[k], bad_num[k] == 12'h0815);
    end
    wr(12'h0814, 32'hC000_0001, 1'b0);
    rd(12'h0814, 32'hC000_0001, 1'b0);
    $display("Test ranges done");
    wr(12'h080B, 32'h0000_012C, 1'b0);
    wr(12'h080C, 32'h0000_000A, 1'b0);
    wr(12'h080E, 32'h0000_00C8, 1'b0);
    wr(12'h080F, 32'h0000_000A, 1'b0);
    @(posedge I_CLK);
    I_CMD_SPEED <= 32'h0000_0009;
    step(3);
    chk("accel below", 32'h0000_0064, O_ACCEL_RATE);
    chk("decel below", 32'h0000_0064, 32'(O_DECEL_RATE));
    @(posedge I_CLK);
    I_CMD_SPEED <= 32'h0000_000A;
    step(3);
    chk("accel at", 32'h0000_012C, O_ACCEL_RATE);
    chk("decel at", 32'h0000_00C8, 32'(O_DECEL_RATE));
    wr(12'h080F, 32'h0000_0000, 1'b0);
    step(3);
    chk("decel off", 32'h0000_0064, 32'(O_DECEL_RATE));
    $display("Test rates done");
    wr(12'h0810, 32'h0000_1234, 1'b0);
    wr(12'h0811, 32'h0000_13EC, 1'b0);
    wr(12'h0812, 32'h0000_0005, 1'b0);
    step(2);
    chk("filter", 32'h1234_13EC, O_FILTER[47:16]);
    chk("average", 32'h0000_0005, 32'(O_FILTER.moving_avg_time));
    $display("Test filters done");
    wr(12'h0827, 32'h0000_012C, 1'b0);
    for (int k = 1; k < 7; k++) begin
      @(posedge I_CLK);
      code <= 3'(k);
      wait_for(want[k-1], 1'b0);
      @(posedge I_CLK);
      code <= 3'h5;
      wait_for(mpp_pkg::MPP_STOP, 1'b0);
      step(2);
      chk("stop decel", 32'h0000_012C, 32'(O_DECEL_RATE));
      @(posedge I_CLK);
      code <= 3'h0;
      wait_for(mpp_pkg::MPP_IDLE, 1'b0);
    end
    $display("Test commands done");
    wr(12'h0814, 32'hFFFF_FF9C, 1'b0);
    wr(12'h0820, 32'h0000_000A, 1'b0);
    @(posedge I_CLK);
    code <= 3'h2;
    wait_for(mpp_pkg::MPP_LATCH_MV, 1'b0);
    code <= 3'h0;
    I_LATCH_PIN <= 1'b1;
    step(8);
    chk("outside window", 32'(mpp_pkg::MPP_LATCH_MV), 32'(O_STATE));
    I_LATCH_PIN <= 1'b0;
    I_POSITION <= 32'sh0000_0005;
    step(3);
    I_LATCH_PIN <= 1'b1;
    wait_for(mpp_pkg::MPP_IDLE, 1'b1);
    chk("latch dist", 32'hFFFF_FF9C, O_TRAVEL_DIST);
    chk("latch taken", 32'h0000_0001, 32'(O_LATCH_TAKEN));
    I_LATCH_PIN <= 1'b0;
    wait_for(mpp_pkg::MPP_IDLE, 1'b0);
    $display("Test latch done");
    wr(12'h0817, 32'h0000_0000, 1'b0);
    wr(12'h0842, 32'h0010_0000, 1'b0);
    wr(12'h0819, 32'h0000_004D, 1'b0);
    @(posedge I_CLK);
    code <= 3'h4;
    wait_for(mpp_pkg::MPP_HOME_APP, 1'b0);
    code <= 3'h0;
    I_HOME_DECEL_SWITCH <= 1'b1;
    wait_for(mpp_pkg::MPP_HOME_C1, 1'b0);
    step(1);
    chk("creep ext", 32'h0010_0000, O_CREEP_SPEED);
    I_HOME_DECEL_SWITCH <= 1'b0;
    I_LATCH_PIN <= 1'b1;
    wait_for(mpp_pkg::MPP_IDLE, 1'b1);
    chk("home dist", 32'h0000_004D, O_TRAVEL_DIST);
    wait_for(mpp_pkg::MPP_IDLE, 1'b0);
    chk("home done", 32'h0000_0001, 32'(O_HOME_DONE));
    chk("creep 2", 32'h0000_0005, O_CREEP_SPEED);
    I_LATCH_PIN <= 1'b0;
    $display("Test homing done");
    wr(12'h0834, 32'h0014_0000, 1'b0);
    wr(12'h0833, 32'h0000_0001, 1'b0);
    rd(12'h0833, 32'h0000_0001, 1'b0);
    chk("set before", 32'h0000_0000, 32'(O_RATE_SET_2));
    @(posedge I_CLK);
    I_RESTART <= 1'b1;
    @(posedge I_CLK);
    I_RESTART <= 1'b0;
    step(3);
    chk("set after", 32'h0000_0001, 32'(O_RATE_SET_2));
    chk("accel set2", 32'h0014_0000, O_ACCEL_RATE);
    $display("Test rate set done");
    print_verdict();
  end
endmodule
`default_nettype wire
